// ### logic/irq_coalesce_pkg.sv
// Shared constants and carriers for the write-channel interrupt coalescing block
package irq_coalesce_pkg;

    // Register map (byte addresses)
    localparam logic [7:0] CTRL_OFFSET = 8'h30;
    localparam logic [7:0] STATUS_OFFSET = 8'h38;

    // Control word field positions
    localparam int COMPLETION_EN_BIT = 12;
    localparam int DELAY_EN_BIT = 13;
    localparam int ERROR_EN_BIT = 14;
    localparam int RESERVED_BIT = 15;
    localparam int THRESHOLD_LSB = 16;
    localparam int DELAY_LSB = 24;

    // Status word field positions
    localparam int STAT_COUNT_LSB = 0;
    localparam int STAT_TIMER_LSB = 8;
    localparam int STAT_RUN_BIT = 16;

    // Reset values
    localparam logic COMPLETION_EN_RESET = 1'h0;
    localparam logic DELAY_EN_RESET = 1'h0;
    localparam logic ERROR_EN_RESET = 1'h0;
    localparam logic [7:0] THRESHOLD_RESET = 8'h01;
    localparam logic [7:0] DELAY_RESET = 8'h00;
    localparam logic [7:0] THRESHOLD_MIN = 8'h01;

    // Delay timer resolution
    localparam int CLK_PERIOD_NS = 20;
    localparam int DELAY_TICK_NS = 1000;
    localparam int DELAY_TICK_CYCLES = DELAY_TICK_NS / CLK_PERIOD_NS;

    typedef enum logic {
        TIMER_IDLE,
        TIMER_COUNTING
    } timer_state_e;

    // Avalon-MM request from the master
    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avmm_req_s;

    // Channel events, one-cycle pulses from the datapath
    typedef struct packed {
        logic completion;
        logic packet_start;
        logic packet_end;
        logic error;
    } dma_event_s;

    // Interrupt requests, one-cycle pulses
    typedef struct packed {
        logic completion;
        logic delay;
        logic error;
    } irq_s;

endpackage

// ### logic/delay_tick_divider.sv
// Prescaler that gives one enable pulse per delay-timer tick
`timescale 1ns/100ps
module delay_tick_divider
    import irq_coalesce_pkg::*;
#(
    parameter int unsigned CYCLES = DELAY_TICK_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Restart the period
    input wire logic clr,
    // One-cycle enable
    output logic tick
);
    localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } div_state_s;

    div_state_s q;
    div_state_s d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (clr) begin
            d.count = '0;
        end else if (q.count == LAST) begin
            d.count = '0;
            d.tick = 1'b1;
        end else begin
            d.count = q.count + W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

// ### logic/stream_to_memory_irq_coalescing.sv
// Interrupt enables, completion coalescing and idle timeout for the write channel
//
// How it works
// - Bit 13 lets delay-timer expiry raise an interrupt; zero masks it.
// - Without descriptor mode the delay interrupt enable is ignored.
// - Bit 14 lets channel errors raise an interrupt; zero suppresses them.
// - Bit 15 is reserved: writes ignored, reads return zero.
// - Threshold in bits 23:16 resets to 1; completions count down from it.
// - A completion with the counter at 1 raises the completion interrupt and reloads it.
// - Threshold is at least 1; writing 0 leaves it unchanged.
// - Without descriptor mode completions are not coalesced.
// - Delay in bits 31:24 resets to 0; timer starts at packet end.
// - Timer resets when a new packet starts or a timeout occurs.
// - Timer reaching the delay value raises the delay interrupt.
// - Delay value zero disables the timer completely.
// - Without descriptor mode the delay field is ignored, timer idle.
// - Bit 12 lets flagged completion events raise the interrupt.
`timescale 1ns/100ps
module stream_to_memory_irq_coalescing
    import irq_coalesce_pkg::*;
#(
    parameter bit DESCRIPTOR_MODE = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire avmm_req_s bus_req,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Channel events
    input wire dma_event_s events,
    // Interrupt requests
    output irq_s irq
);

    typedef struct packed {
        logic waitrequest;
        logic [31:0] readdata;
        logic completion_en;
        logic delay_en;
        logic error_en;
        logic [7:0] threshold;
        logic [7:0] idle_setting;
        logic [7:0] count;
        timer_state_e tstate;
        logic [7:0] timer;
        irq_s irq;
    } state_s;

    state_s q;
    state_s d;

    logic tick;
    logic timer_restart;
    logic wr_take;
    logic wr_ctrl;
    logic rd_take;
    logic thr_reload;
    logic [7:0] thr_next;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic timer_on;
    logic comp_fire;

    // Register images
    always_comb begin
        ctrl_word = '0;
        ctrl_word[COMPLETION_EN_BIT] = q.completion_en;
        ctrl_word[DELAY_EN_BIT] = q.delay_en;
        ctrl_word[ERROR_EN_BIT] = q.error_en;
        ctrl_word[RESERVED_BIT] = 1'b0;
        ctrl_word[THRESHOLD_LSB +: 8] = q.threshold;
        ctrl_word[DELAY_LSB +: 8] = q.idle_setting;
    end

    always_comb begin
        status_word = '0;
        status_word[STAT_COUNT_LSB +: 8] = q.count;
        status_word[STAT_TIMER_LSB +: 8] = q.timer;
        status_word[STAT_RUN_BIT] = (q.tstate == TIMER_COUNTING);
    end

    // A request completes at the edge where waitrequest is sampled low
    assign rd_take = bus_req.read && !q.waitrequest;
    assign wr_take = bus_req.write && !q.waitrequest;
    assign wr_ctrl = wr_take && (bus_req.address == CTRL_OFFSET);

    // Threshold update; zero is refused
    always_comb begin
        thr_next = q.threshold;
        thr_reload = 1'b0;
        if (wr_ctrl && bus_req.byteenable[2] &&
            bus_req.writedata[THRESHOLD_LSB +: 8] >= THRESHOLD_MIN) begin
            thr_next = bus_req.writedata[THRESHOLD_LSB +: 8];
            thr_reload = (thr_next != q.threshold);
        end
    end

    // Delay timer runs only with a nonzero delay in descriptor mode
    assign timer_on = DESCRIPTOR_MODE && (q.idle_setting != 8'h00);

    // Divider period restarts with every fresh count
    assign timer_restart = events.packet_end || q.tstate != TIMER_COUNTING;

    delay_tick_divider #(
        .CYCLES(DELAY_TICK_CYCLES)
    ) u_tick (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clr(timer_restart),
        .tick(tick)
    );

    always_comb begin
        d = q;
        d.irq = '0;
        comp_fire = 1'b0;

        // Bus handshake: one wait cycle, then a single ready cycle
        d.waitrequest = 1'b1;
        if ((bus_req.read || bus_req.write) && q.waitrequest) begin
            d.waitrequest = 1'b0;
            case (bus_req.address)
                CTRL_OFFSET: d.readdata = ctrl_word;
                STATUS_OFFSET: d.readdata = status_word;
                default: d.readdata = '0;
            endcase
        end

        // Control write, per byte lane; bit 15 is not stored
        if (wr_ctrl && bus_req.byteenable[1]) begin
            d.completion_en = bus_req.writedata[COMPLETION_EN_BIT];
            d.delay_en = bus_req.writedata[DELAY_EN_BIT];
            d.error_en = bus_req.writedata[ERROR_EN_BIT];
        end
        d.threshold = thr_next;
        if (wr_ctrl && bus_req.byteenable[3]) begin
            d.idle_setting = bus_req.writedata[DELAY_LSB +: 8];
        end

        // Completion coalescing
        d.count = thr_reload ? thr_next : q.count;
        if (events.completion) begin
            if (!DESCRIPTOR_MODE) begin
                comp_fire = 1'b1;
            end else if (d.count == 8'h01) begin
                comp_fire = 1'b1;
                d.count = thr_next;
            end else begin
                d.count = d.count - 8'h01;
            end
        end
        d.irq.completion = comp_fire && q.completion_en;

        // Idle timeout
        case (q.tstate)
            TIMER_IDLE: begin
                d.timer = 8'h00;
                if (events.packet_end && timer_on) begin
                    d.tstate = TIMER_COUNTING;
                end
            end
            TIMER_COUNTING: begin
                if (!timer_on || events.packet_start) begin
                    d.tstate = TIMER_IDLE;
                    d.timer = 8'h00;
                end else if (events.packet_end) begin
                    d.timer = 8'h00;
                end else if (tick) begin
                    if (q.timer + 8'h01 == q.idle_setting) begin
                        d.irq.delay = q.delay_en && DESCRIPTOR_MODE;
                        d.tstate = TIMER_IDLE;
                        d.timer = 8'h00;
                    end else begin
                        d.timer = q.timer + 8'h01;
                    end
                end
            end
            default: begin
                d.tstate = TIMER_IDLE;
                d.timer = 8'h00;
            end
        endcase

        // Errors
        d.irq.error = events.error && q.error_en;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            q.waitrequest <= 1'b1;
            q.readdata <= '0;
            q.completion_en <= COMPLETION_EN_RESET;
            q.delay_en <= DELAY_EN_RESET;
            q.error_en <= ERROR_EN_RESET;
            q.threshold <= THRESHOLD_RESET;
            q.idle_setting <= DELAY_RESET;
            q.count <= THRESHOLD_RESET;
            q.tstate <= TIMER_IDLE;
            q.timer <= 8'h00;
            q.irq <= '0;
        end else begin
            q <= d;
        end
    end

    assign readdata = q.readdata;
    assign waitrequest = q.waitrequest;
    assign irq = q.irq;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    reserved_reads_zero_a: assert property (
        !q.waitrequest && bus_req.read && bus_req.address == CTRL_OFFSET
        |-> readdata[RESERVED_BIT] == 1'b0 && readdata[11:0] == 12'h000)
        else $error("reserved control bits read nonzero");

    threshold_nonzero_a: assert property (
        q.threshold != 8'h00)
        else $error("threshold holds zero");

    zero_write_kept_a: assert property (
        wr_ctrl && bus_req.byteenable[2]
        && bus_req.writedata[THRESHOLD_LSB +: 8] == 8'h00
        |=> $stable(q.threshold))
        else $error("zero threshold write changed the threshold");

    count_range_a: assert property (
        q.count >= 8'h01 && q.count <= q.threshold)
        else $error("coalescing counter out of range");

    threshold_reload_a: assert property (
        thr_reload && !events.completion |=> q.count == q.threshold)
        else $error("threshold change did not reload the counter");

    fire_reloads_a: assert property (
        DESCRIPTOR_MODE && events.completion && !thr_reload && q.count == 8'h01
        |=> q.count == q.threshold && irq.completion == $past(q.completion_en))
        else $error("counter at one did not fire and reload");

    count_down_a: assert property (
        DESCRIPTOR_MODE && events.completion && !thr_reload && q.count > 8'h01
        |=> q.count == $past(q.count) - 8'h01 && !irq.completion)
        else $error("completion did not count down");

    completion_mask_a: assert property (
        !q.completion_en |=> !irq.completion)
        else $error("completion interrupt while disabled");

    simple_mode_pass_a: assert property (
        !DESCRIPTOR_MODE && events.completion |=> irq.completion == $past(q.completion_en))
        else $error("simple mode completion not passed through");

    error_irq_a: assert property (
        events.error |=> irq.error == $past(q.error_en))
        else $error("error interrupt does not follow enable");

    error_cause_a: assert property (
        irq.error |-> $past(events.error))
        else $error("error interrupt without an error event");

    delay_cause_a: assert property (
        irq.delay |-> $past(q.delay_en) && $past(tick)
        && $past(q.timer) + 8'h01 == $past(q.idle_setting))
        else $error("delay interrupt without timer reaching the delay value");

    simple_no_delay_a: assert property (
        !DESCRIPTOR_MODE |-> q.tstate == TIMER_IDLE && !irq.delay)
        else $error("delay timer active without descriptor mode");

    delay_zero_idle_a: assert property (
        q.idle_setting == 8'h00 |=> q.tstate == TIMER_IDLE)
        else $error("delay timer runs with zero delay");

    packet_start_a: assert property (
        events.packet_start |=> q.tstate == TIMER_IDLE && q.timer == 8'h00)
        else $error("new packet did not reset the delay timer");

    packet_end_start_a: assert property (
        events.packet_end && !events.packet_start && timer_on
        |=> q.tstate == TIMER_COUNTING && q.timer == 8'h00)
        else $error("packet end did not start the delay timer");

    bus_answer_a: assert property (
        (bus_req.read || bus_req.write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle after the request");

    idle_timer_zero_a: assert property (
        q.tstate == TIMER_IDLE |-> q.timer == 8'h00)
        else $error("idle delay timer holds a count");

    delay_mask_a: assert property (
        !q.delay_en |=> !irq.delay)
        else $error("delay interrupt while disabled");

    error_mask_a: assert property (
        !q.error_en |=> !irq.error)
        else $error("error interrupt while disabled");

    delay_field_write_a: assert property (
        wr_ctrl && bus_req.byteenable[3]
        |=> q.idle_setting == $past(bus_req.writedata[DELAY_LSB +: 8]))
        else $error("delay field write did not land");

    enable_write_a: assert property (
        wr_ctrl && bus_req.byteenable[1]
        |=> {q.error_en, q.delay_en, q.completion_en}
            == $past(bus_req.writedata[COMPLETION_EN_BIT +: 3]))
        else $error("enable bits write did not land");

    threshold_write_a: assert property (
        wr_ctrl && bus_req.byteenable[2]
        && bus_req.writedata[THRESHOLD_LSB +: 8] != 8'h00
        |=> q.threshold == $past(bus_req.writedata[THRESHOLD_LSB +: 8]))
        else $error("threshold write did not land");

    completion_cause_a: assert property (
        irq.completion |-> $past(events.completion))
        else $error("completion interrupt without a completion event");

    threshold_readback_a: assert property (
        !q.waitrequest && bus_req.read && bus_req.address == CTRL_OFFSET
        |-> readdata[THRESHOLD_LSB +: 8] == q.threshold)
        else $error("threshold read back differs from the stored value");

    coalesce_fire_c: cover property (
        DESCRIPTOR_MODE && q.threshold > 8'h02 && irq.completion);

    delay_timeout_c: cover property (
        irq.delay);

    restart_by_packet_c: cover property (
        q.tstate == TIMER_COUNTING ##1 events.packet_start);

    error_irq_c: cover property (
        irq.error);

    reload_then_count_c: cover property (
        thr_reload ##1 events.completion);

endmodule

// ### sim/tb_top.sv
// Self-checking bench for the write-channel interrupt coalescing block
`timescale 1ns/100ps
module tb_top
    import irq_coalesce_pkg::*;
;
    logic ref_clk;
    logic reset_n;
    avmm_req_s bus_req;
    dma_event_s events;
    logic [31:0] readdata;
    logic [31:0] rd_b;
    logic waitrequest;
    logic wr_b;
    irq_s irq;
    irq_s irq_b;
    logic [7:0] lfsr_q;
    logic [31:0] ctrl_m;
    logic [31:0] rv;
    logic [31:0] wd;
    logic [7:0] n;
    int miscompares;
    int samples_checked;
    int cnt_c, cnt_d, cnt_e, cnt_cb, cnt_db, cnt_eb;

    stream_to_memory_irq_coalescing #(.DESCRIPTOR_MODE(1'b1)) i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .bus_req(bus_req), .readdata(readdata), .waitrequest(waitrequest),
        .events(events), .irq(irq));
    // Simple transfer build sharing all inputs
    stream_to_memory_irq_coalescing #(.DESCRIPTOR_MODE(1'b0)) i_dut_simple (.ref_clk(ref_clk),
        .reset_n(reset_n), .bus_req(bus_req), .readdata(rd_b), .waitrequest(wr_b),
        .events(events), .irq(irq_b));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cnt_c <= cnt_c + int'(irq.completion === 1'b1);
        cnt_d <= cnt_d + int'(irq.delay === 1'b1);
        cnt_e <= cnt_e + int'(irq.error === 1'b1);
        cnt_cb <= cnt_cb + int'(irq_b.completion === 1'b1);
        cnt_db <= cnt_db + int'(irq_b.delay === 1'b1);
        cnt_eb <= cnt_eb + int'(irq_b.error === 1'b1);
    end

    function automatic logic [31:0] apply_wr(logic [31:0] old, logic [31:0] d, logic [3:0] be);
        logic [31:0] r;
        r = old;
        if (be[1]) r[14:12] = d[14:12];
        if (be[2] && d[23:16] != 8'h00) r[23:16] = d[23:16];
        if (be[3]) r[31:24] = d[31:24];
        return r;
    endfunction

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic rnd8(output logic [7:0] v);
        lfsr_q = lfsr_next(lfsr_q);
        v = lfsr_q;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_op(input logic rd, input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        int k;
        @(posedge ref_clk);
        bus_req <= '{read: rd, write: !rd, address: a, writedata: d, byteenable: be};
        for (k = 0; k < 50; k++) begin
            @(posedge ref_clk);
            if (waitrequest === 1'b0) break;
        end
        q = readdata;
        if (k == 50) miscompares++;
        bus_req <= '0;
    endtask

    task automatic wr_ctrl(input logic [31:0] d, input logic [3:0] be);
        bus_op(1'b0, CTRL_OFFSET, d, be, rv);
        ctrl_m = apply_wr(ctrl_m, d, be);
    endtask

    task automatic pulse(input dma_event_s e, input int gap);
        @(posedge ref_clk);
        events <= e;
        @(posedge ref_clk);
        events <= '0;
        // Two more edges so the interrupt counters show the answer
        repeat (gap + 2) @(posedge ref_clk);
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_sim;
    end

    initial begin
        logic [31:0] tbl [3];
        int base;
        reset_n = 1'b0;
        bus_req = '0;
        events = '0;
        lfsr_q = 8'h48;
        {cnt_c, cnt_d, cnt_e, cnt_cb, cnt_db, cnt_eb} = '0;
        miscompares = 0;
        samples_checked = 0;
        ctrl_m = 32'h0001_0000;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);

        bus_op(1'b1, CTRL_OFFSET, '0, 4'hf, rv);
        check(rv, 32'h0001_0000);
        bus_op(1'b1, STATUS_OFFSET, '0, 4'hf, rv);
        check(rv, 32'h0000_0001);
        check(rd_b, 32'h0000_0001);
        check(32'(wr_b), 32'h0);
        bus_op(1'b0, 8'h3c, 32'hffff_ffff, 4'hf, rv);
        bus_op(1'b1, 8'h3c, '0, 4'hf, rv);
        check(rv, 32'h0);
        $display("test reset_values done");

        // Random writes with a zero threshold corner first
        for (int i = 0; i < 8; i++) begin
            rnd8(wd[31:24]);
            rnd8(wd[23:16]);
            rnd8(wd[15:8]);
            rnd8(wd[7:0]);
            if (i == 0) wd[23:16] = 8'h00;
            wr_ctrl(wd, (i < 2) ? 4'hf : wd[3:0] | 4'h4);
            bus_op(1'b1, CTRL_OFFSET, '0, 4'hf, rv);
            check(rv, ctrl_m);
        end
        $display("test register_access done");

        rnd8(n);
        n = {6'h0, n[1:0]} + 8'h01;
        wr_ctrl({8'h00, n, 16'h5000}, 4'hf);
        base = cnt_c;
        for (int i = 1; i <= 2 * n; i++) begin
            pulse('{completion: 1'b1, default: 1'b0}, i % 3);
            check(32'(cnt_c - base), 32'(i / n));
        end
        check(32'(cnt_cb - base), 32'(2 * n));
        wr_ctrl({8'h00, n, 16'h4000}, 4'hf);
        repeat (n) pulse('{completion: 1'b1, default: 1'b0}, 1);
        check(32'(cnt_c - base), 32'h2);
        check(32'(cnt_cb - base), 32'(2 * n));
        $display("test coalescing done");

        wr_ctrl(32'h0003_1000, 4'hf);
        base = cnt_c;
        repeat (2) pulse('{completion: 1'b1, default: 1'b0}, 1);
        wr_ctrl(32'h0002_5000, 4'hf);
        pulse('{completion: 1'b1, default: 1'b0}, 1);
        check(32'(cnt_c - base), 32'h0);
        pulse('{completion: 1'b1, default: 1'b0}, 1);
        check(32'(cnt_c - base), 32'h1);
        $display("test threshold_reload done");

        base = cnt_e;
        pulse('{error: 1'b1, default: 1'b0}, 1);
        check(32'(cnt_e - base), 32'h1);
        wr_ctrl(32'h0001_0000, 4'hf);
        pulse('{error: 1'b1, default: 1'b0}, 1);
        check(32'(cnt_e - base), 32'h1);
        check(32'(cnt_eb), 32'h1);
        $display("test error_irq done");

        tbl = '{32'h0200_2000, 32'h0200_0000, 32'h0000_2000};
        for (int i = 0; i < 3; i++) begin
            wr_ctrl(tbl[i], 4'hf);
            base = cnt_d;
            pulse('{packet_end: 1'b1, default: 1'b0}, 40);
            check(32'(cnt_d - base), 32'h0);
            bus_op(1'b1, STATUS_OFFSET, '0, 4'hf, rv);
            check(rv, (i == 2) ? 32'h0000_0001 : 32'h0001_0001);
            repeat (220) @(posedge ref_clk);
            check(32'(cnt_d - base), 32'(i == 0));
        end
        check(32'(cnt_db), 32'h0);
        wr_ctrl(32'h0200_2000, 4'hf);
        base = cnt_d;
        pulse('{packet_end: 1'b1, default: 1'b0}, 60);
        pulse('{packet_start: 1'b1, default: 1'b0}, 200);
        check(32'(cnt_d - base), 32'h0);
        $display("test delay_timer done");
        end_sim;
    end
endmodule
